/* File: rtl/strap_config_clock.sv */
// Purpose: Strap decode, host settings and switching clock control
// Assumes: AXI4-Lite slave, one outstanding read and write
// Notes: Strap settings hold until reset or a host write overrides them
`timescale 1ns/10ps
// Function
// - Sample straps once at power-up, decode, apply before regulation may start
// - Switching frequency 200 kHz to 1 MHz from host command 33h, 500 kHz after reset
// - Switching clock is the 30 MHz reference divided by N, 30 to 150
// - Non-exact host frequency picks the whole-number divider giving the nearest frequency
// - Accept an external clock on the sync pin in external mode
// - Drive the sync pin as clock output when on the internal oscillator
// - External clock loss sets the period fault flag and shuts output down
// - After loss, next enable runs internal oscillator at programmed frequency
// - Sync resumes only after reset or host reselecting external clock
// - Fault strap gives retry, diode emulation, 20 to 50 A; open is code 1
// - Gain strap gives gain 250 to 1000 and clock choice; open is code 2
// - Strapped gain fixes residual at 79 and integral at 100
// - Derived current limits at 1, 0.8, 0.7, -0.8, -1 times the limit
// - All settings host-readable, all but the derived limits host-writable; store request to config_store
module strap_config_clock
  import strap_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ref_tick,
  input wire logic [3:0] fault_limit_strap,
  input wire logic [3:0] gain_clocksel_strap,
  input wire logic enable_pin,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic sw_clk,
  output logic run,
  output logic store_req,
  output strap_cfg_pkg::fault_cfg_t fault_cfg,
  output strap_cfg_pkg::tuning_t loop_tuning,
  output strap_cfg_pkg::limits_t limits,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import strap_cfg_pkg::*;

  typedef enum logic [1:0] {ST_STRAP = 2'b00, ST_IDLE = 2'b01, ST_RUN = 2'b10,
    ST_FAULT = 2'b11} state_t;

  // Nearest frequency, not nearest divider: the two differ near half steps
  function automatic logic [7:0] khz_to_div(input logic [15:0] khz);
    logic [31:0] k;
    logic [31:0] q;
    k = {16'h0, khz};
    q = 32'd0;
    if (khz < FREQ_MIN_KHZ)
      return DIV_MAX;
    if (khz > FREQ_MAX_KHZ)
      return DIV_MIN;
    q = 32'd30000 / k;
    if (32'd2 * k * q * (q + 32'd1) < 32'd30000 * (32'd2 * q + 32'd1))
      q = q + 32'd1;
    return q[7:0];
  endfunction

  function automatic logic [15:0] div_to_khz(input logic [7:0] n);
    logic [15:0] q;
    q = 16'(32'd30000 / {24'h0, n});
    return q;
  endfunction

  function automatic limits_t derive(input logic [7:0] a);
    limits_t l;
    l.oc_fault = a;
    l.avg_oc_fault = 8'((16'(a) * 16'h0004) / 16'h0005);
    l.oc_warn = 8'((16'(a) * 16'h0007) / 16'h000a);
    l.avg_uc_fault = -l.avg_oc_fault;
    l.uc_fault = -a;
    return l;
  endfunction

  function automatic logic [15:0] gain_of(input logic [2:0] c);
    case (c)
      3'h0: return 16'h00fa;
      3'h1: return 16'h012c;
      3'h2: return 16'h0190;
      3'h3: return 16'h01f4;
      3'h4: return 16'h0258;
      3'h5: return 16'h02bc;
      3'h6: return 16'h0320;
      default: return 16'h03e8;
    endcase
  endfunction

  logic [3:0] fault_code, gain_code;
  logic strap_done;
  logic sy1_ff, sy2_ff, sy3_ff, sync_lvl_ff;
  logic en1_ff, en2_ff, en3_ff, en_lvl_ff;
  logic ext_lost, gen_clk;
  logic use_ext_ff, ext_sel_ff, ext_fault_ff, applied_ff;
  logic [7:0] div_ff;
  state_t state_ff;
  logic wr_go, aw_ok, w_ok;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic aw_have_ff, w_have_ff;

  strap_sampler u_sampler (
    .clk(clk),
    .resetn(resetn),
    .fault_limit_strap(fault_limit_strap),
    .gain_clocksel_strap(gain_clocksel_strap),
    .fault_code(fault_code),
    .gain_code(gain_code),
    .done(strap_done)
  );

  switch_clock_gen u_clkgen (
    .clk(clk),
    .resetn(resetn),
    .ref_tick(ref_tick),
    .divider(div_ff),
    .use_ext(use_ext_ff),
    .sync_level(sync_lvl_ff),
    .sw_clk(gen_clk),
    .ext_lost(ext_lost)
  );

  // Pin filters: level changes once stages two and three agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {sy1_ff, sy2_ff, sy3_ff, sync_lvl_ff} <= 4'h0;
      {en1_ff, en2_ff, en3_ff, en_lvl_ff} <= 4'h0;
    end
    else
    begin
      sy1_ff <= sync_in;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      if (sy2_ff == sy3_ff)
        sync_lvl_ff <= sy3_ff;
      en1_ff <= enable_pin;
      en2_ff <= en1_ff;
      en3_ff <= en2_ff;
      if (en2_ff == en3_ff)
        en_lvl_ff <= en3_ff;
    end
  end

  // AXI write channel capture, either order
  assign aw_ok = s_axi_awvalid && s_axi_awready;
  assign w_ok = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_ff && !aw_ok;
      s_axi_wready <= !w_have_ff && !w_ok;
      if (aw_ok)
      begin
        aw_have_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_ok)
      begin
        w_have_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go)
      begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff <= OFS_STORE && awaddr_ff[1:0] == 2'b00
          && awaddr_ff != OFS_LIMITS && awaddr_ff != OFS_MFR_STATUS) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Settings: strap decode first, host writes override afterwards
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      applied_ff <= 1'b0;
      div_ff <= DIV_DEFAULT;
      ext_sel_ff <= 1'b0;
      fault_cfg <= '0;
      loop_tuning <= '0;
      limits <= '0;
      store_req <= 1'b0;
    end
    else
    begin
      store_req <= 1'b0;
      if (strap_done && !applied_ff)
      begin
        applied_ff <= 1'b1;
        fault_cfg.retry <= fault_code[3];
        fault_cfg.diode_emul <= fault_code[2];
        fault_cfg.limit_a <= 8'h14 + 8'(fault_code[1:0]) * 8'h0a;
        limits <= derive(8'h14 + 8'(fault_code[1:0]) * 8'h0a);
        loop_tuning.gain <= gain_of(gain_code[2:0]);
        loop_tuning.residual <= RESIDUAL_FIXED;
        loop_tuning.integral <= INTEGRAL_FIXED;
        ext_sel_ff <= gain_code[3];
      end
      else if (wr_go && applied_ff)
      begin
        case (awaddr_ff)
          OFS_FREQ: if (s_axi_wstrb[1:0] == 2'b11)
            div_ff <= khz_to_div(wdata_ff[15:0]);
          OFS_OPTIONS: if (s_axi_wstrb[0])
            ext_sel_ff <= wdata_ff[0];
          OFS_FAULT_LIMIT: if (s_axi_wstrb[0])
          begin
            fault_cfg.retry <= wdata_ff[9];
            fault_cfg.diode_emul <= wdata_ff[8];
            fault_cfg.limit_a <= wdata_ff[7:0];
            limits <= derive(wdata_ff[7:0]);
          end
          OFS_LOOP_TUNING: if (s_axi_wstrb == 4'hf)
            loop_tuning <= wdata_ff;
          OFS_STORE: store_req <= wdata_ff[0];
          default: ;
        endcase
      end
    end
  end

  // Sync ownership, loss fault and enable sequencing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_STRAP;
      use_ext_ff <= 1'b0;
      ext_fault_ff <= 1'b0;
      run <= 1'b0;
      sync_oe <= 1'b0;
      sync_out <= 1'b0;
      sw_clk <= 1'b0;
    end
    else
    begin
      if (wr_go && awaddr_ff == OFS_OPTIONS && s_axi_wstrb[0] && wdata_ff[0])
        use_ext_ff <= 1'b1;
      else if (wr_go && awaddr_ff == OFS_OPTIONS && s_axi_wstrb[0])
        use_ext_ff <= 1'b0;
      else if (ext_lost)
        use_ext_ff <= 1'b0;
      else if (state_ff == ST_STRAP && applied_ff)
        use_ext_ff <= ext_sel_ff;
      if (ext_lost)
        ext_fault_ff <= 1'b1;
      sync_oe <= !use_ext_ff;
      sync_out <= gen_clk;
      sw_clk <= gen_clk && run;
      case (state_ff)
        ST_STRAP: if (applied_ff) state_ff <= ST_IDLE;
        ST_IDLE: if (en_lvl_ff)
        begin
          state_ff <= ST_RUN;
          run <= 1'b1;
        end
        ST_RUN: if (ext_lost)
        begin
          state_ff <= ST_FAULT;
          run <= 1'b0;
        end
        else if (!en_lvl_ff)
        begin
          state_ff <= ST_IDLE;
          run <= 1'b0;
        end
        ST_FAULT: if (!en_lvl_ff) state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      case (s_axi_araddr)
        OFS_FREQ: s_axi_rdata <= {8'h0, div_ff, div_to_khz(div_ff)};
        OFS_OPTIONS: s_axi_rdata <= {31'h0, ext_sel_ff};
        OFS_FAULT_LIMIT: s_axi_rdata <= {22'h0, fault_cfg};
        OFS_LOOP_TUNING: s_axi_rdata <= loop_tuning;
        OFS_LIMITS: s_axi_rdata <= limits[39:8];
        OFS_MFR_STATUS: s_axi_rdata <= {27'h0, state_ff, use_ext_ff, run, ext_fault_ff};
        OFS_CONTROL: s_axi_rdata <= {24'h0, limits[7:0]};
        OFS_STORE: s_axi_rdata <= 32'h0;
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end
    else
      s_axi_arready <= 1'b1;
  end

  no_run_early_a: assert property (@(posedge clk) disable iff (!resetn)
    run |-> applied_ff)
    else $error("regulation before straps applied");
  loss_shutdown_a: assert property (@(posedge clk) disable iff (!resetn)
    ext_lost && state_ff == ST_RUN |=> !run && ext_fault_ff)
    else $error("clock loss did not shut down");
  sync_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    !use_ext_ff |=> sync_oe)
    else $error("sync pin not driven on internal clock");
  div_range_a: assert property (@(posedge clk) disable iff (!resetn)
    div_ff >= DIV_MIN && div_ff <= DIV_MAX)
    else $error("divider out of range");
  fixed_tuning_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(applied_ff) |-> loop_tuning.residual == 8'h4f && loop_tuning.integral == 8'h64)
    else $error("strapped tuning not fixed");
  derived_lim_a: assert property (@(posedge clk) disable iff (!resetn)
    limits.uc_fault == -limits.oc_fault)
    else $error("limits not symmetric");
  fallback_int_a: assert property (@(posedge clk) disable iff (!resetn)
    ext_lost && !wr_go |=> !use_ext_ff)
    else $error("external clock kept after loss");
  strap_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    applied_ff && !wr_go |=> $stable(fault_cfg))
    else $error("fault settings moved without write");
endmodule

/* File: rtl/strap_cfg_pkg.sv */
// Purpose: Shared constants and types for strap decode and switching clock
// Assumes: 50 MHz system clock, 30 MHz reference arrives as a one-cycle enable
// Notes: Register byte offsets are word aligned on AXI4-Lite
package strap_cfg_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned REF_HZ = 30000000;
  localparam logic [7:0] DIV_MIN = 8'h1e;
  localparam logic [7:0] DIV_MAX = 8'h96;
  localparam logic [7:0] DIV_DEFAULT = 8'h3c;
  localparam logic [15:0] FREQ_MIN_KHZ = 16'h00c8;
  localparam logic [15:0] FREQ_MAX_KHZ = 16'h03e8;
  localparam logic [7:0] CMD_FREQUENCY_SWITCH = 8'h33;
  localparam logic [7:0] CMD_MFR_STATUS = 8'h80;
  localparam logic [7:0] CMD_LOOP_TUNING = 8'hdf;
  // AXI byte offsets
  localparam logic [7:0] OFS_FREQ = 8'h00;
  localparam logic [7:0] OFS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_FAULT_LIMIT = 8'h08;
  localparam logic [7:0] OFS_LOOP_TUNING = 8'h0c;
  localparam logic [7:0] OFS_LIMITS = 8'h10;
  localparam logic [7:0] OFS_MFR_STATUS = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_STORE = 8'h1c;
  localparam logic [7:0] RESIDUAL_FIXED = 8'h4f;
  localparam logic [7:0] INTEGRAL_FIXED = 8'h64;
  localparam logic [3:0] OPEN_CODE_FAULT = 4'h1;
  localparam logic [3:0] OPEN_CODE_GAIN = 4'h2;
  localparam logic [7:0] STRAP_SETTLE_CYC = 8'h10;
  // Clock loss: no edge seen for this many 50 MHz cycles (>5 us at 200 kHz)
  localparam int unsigned LOSS_TIME_NS = 10000;
  localparam int unsigned LOSS_CYC = LOSS_TIME_NS / 20;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef struct packed {
    logic retry;
    logic diode_emul;
    logic [7:0] limit_a;
  } fault_cfg_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [7:0] residual;
    logic [7:0] integral;
  } tuning_t;

  typedef struct packed {
    logic signed [7:0] oc_fault;
    logic signed [7:0] avg_oc_fault;
    logic signed [7:0] oc_warn;
    logic signed [7:0] avg_uc_fault;
    logic signed [7:0] uc_fault;
  } limits_t;
endpackage

/* File: rtl/strap_sampler.sv */
// Purpose: Synchronise and latch the two 4-bit strap codes once after reset
// Assumes: Strap codes come from the pin reader, asynchronous to clk
// Notes: Later strap changes are ignored until the next reset
`timescale 1ns/10ps
module strap_sampler
  import strap_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] fault_limit_strap,
  input wire logic [3:0] gain_clocksel_strap,
  output logic [3:0] fault_code,
  output logic [3:0] gain_code,
  output logic done
);
  logic [7:0] s1_ff, s2_ff, s3_ff;
  logic [7:0] settle_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
    end
    else
    begin
      s1_ff <= {fault_limit_strap, gain_clocksel_strap};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Wait for a steady code before sampling once
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      settle_ff <= 8'h00;
      done <= 1'b0;
      fault_code <= OPEN_CODE_FAULT;
      gain_code <= OPEN_CODE_GAIN;
    end
    else if (!done)
    begin
      if (s2_ff != s3_ff)
        settle_ff <= 8'h00;
      else if (settle_ff == STRAP_SETTLE_CYC)
      begin
        done <= 1'b1;
        fault_code <= s3_ff[7:4];
        gain_code <= s3_ff[3:0];
      end
      else
        settle_ff <= settle_ff + 8'h01;
    end
  end

  sample_once_a: assert property (@(posedge clk) disable iff (!resetn)
    done |=> done && $stable(fault_code) && $stable(gain_code))
    else $error("strap code changed after sampling");
endmodule

/* File: rtl/switch_clock_gen.sv */
// Purpose: Divide the reference enable into the switching clock, watch sync
// Assumes: ref_tick is a one-cycle enable at the reference rate
// Notes: External sync mode follows the filtered sync pin edges
`timescale 1ns/10ps
module switch_clock_gen
  import strap_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ref_tick,
  input wire logic [7:0] divider,
  input wire logic use_ext,
  input wire logic sync_level,
  output logic sw_clk,
  output logic ext_lost
);
  logic [7:0] cnt_ff;
  logic int_clk_ff;
  logic sync_d_ff;
  logic [9:0] idle_ff;
  logic sync_rise;

  assign sync_rise = sync_level && !sync_d_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff <= 8'h00;
      int_clk_ff <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (cnt_ff >= divider - 8'h01)
        cnt_ff <= 8'h00;
      else
        cnt_ff <= cnt_ff + 8'h01;
      int_clk_ff <= (cnt_ff < {1'b0, divider[7:1]});
    end
  end

  // Loss watchdog counts system cycles between sync edges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_d_ff <= 1'b0;
      idle_ff <= 10'h000;
      ext_lost <= 1'b0;
      sw_clk <= 1'b0;
    end
    else
    begin
      sync_d_ff <= sync_level;
      if (!use_ext || sync_rise)
        idle_ff <= 10'h000;
      else if (idle_ff != 10'(LOSS_CYC))
        idle_ff <= idle_ff + 10'h001;
      ext_lost <= use_ext && (idle_ff == 10'(LOSS_CYC));
      sw_clk <= use_ext ? sync_level : int_clk_ff;
    end
  end
endmodule

/* File: tb/ext_clk_src.sv */
// Purpose: External switching clock source on the sync pin
// Assumes: Stands still at low while switched off
// Notes: Odd start offset keeps its phase unrelated to clk
`timescale 1ns/10ps
module ext_clk_src #(parameter int HALF_NS = 900)
(
  input wire logic on,
  output logic level
);
  initial
  begin
    level = 1'b0;
    #7.3;
    forever
    begin
      #(HALF_NS);
      level = on ? ~level : 1'b0;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for strap decode and switching clock
// Assumes: AXI4-Lite host tasks, external clock from ext_clk_src
// Notes: Period checks count clk cycles over three switching periods
`timescale 1ns/10ps
module tb_top;
  import strap_cfg_pkg::*;
  logic clk, resetn, ref_tick, enable_pin, ext_on, ext_lvl, sync_in;
  logic [3:0] fls, gcs, wstrb;
  logic sync_out, sync_oe, sw_clk, run, store_req;
  fault_cfg_t fault_cfg;
  tuning_t loop_tuning;
  limits_t limits;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int error_cnt, compares, st_cnt, tc, c;
  strap_config_clock DUT (.clk(clk), .resetn(resetn), .ref_tick(ref_tick),
    .fault_limit_strap(fls), .gain_clocksel_strap(gcs), .enable_pin(enable_pin),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe), .sw_clk(sw_clk),
    .run(run), .store_req(store_req), .fault_cfg(fault_cfg),
    .loop_tuning(loop_tuning), .limits(limits),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ext_clk_src src (.on(ext_on), .level(ext_lvl));
  // Wire level: device drives while enabled, else the far source
  assign sync_in = sync_oe ? sync_out : ext_lvl;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Three ticks in five cycles gives 30 MHz at 50 MHz
  always @(posedge clk)
  begin
    tc <= (tc == 4) ? 0 : tc + 1;
    ref_tick <= (tc != 1) && (tc != 3);
  end
  always @(posedge clk) if (store_req === 1'b1) st_cnt++;
  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk);
      aw |= (awready === 1'b1);
      w |= (wready === 1'b1);
      awvalid <= !aw;
      wvalid <= !w;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  // Cycles spanned by three periods (four rising edges) of the switching clock
  task automatic meas(output int cy);
    int k, n;
    logic p;
    k = 0;
    n = 0;
    cy = 0;
    p = 1'b1;
    while (k < 4 && n < 3000)
    begin
      @(posedge clk);
      n++;
      if (k > 0) cy++;
      if (sw_clk === 1'b1 && p === 1'b0) k++;
      p = sw_clk;
    end
  endtask
  function automatic logic [7:0] lim(input logic [3:0] f);
    return 8'd20 + 8'd10 * f[1:0];
  endfunction
  function automatic logic [15:0] gain(input logic [3:0] g);
    logic [15:0] t [8] = '{16'd250, 16'd300, 16'd400, 16'd500, 16'd600, 16'd700,
      16'd800, 16'd1000};
    return t[g[2:0]];
  endfunction
  // Divider whose frequency lies closest to the request
  function automatic int ndiv(input int khz);
    int n;
    n = 30000 / khz;
    if (khz - 30000.0 / (n + 1) < 30000.0 / n - khz)
      n++;
    return n;
  endfunction
  task automatic chk_straps(input logic [3:0] f, input logic [3:0] g);
    logic [7:0] l;
    l = lim(f);
    chk("fault_cfg", fault_cfg, {f[3], f[2], l});
    chk("limits", limits, {l, 8'(l * 4 / 5), 8'(l * 7 / 10), 8'(-(l * 4 / 5)), -l});
    chk("loop_tuning", loop_tuning, {gain(g), RESIDUAL_FIXED, INTEGRAL_FIXED});
    rdr(OFS_MFR_STATUS, rd, r);
    chk("clock_choice", rd[2], g[3]);
  endtask
  task automatic chk_period(input int n);
    meas(c);
    chk("period", (c >= 5 * n - 3) && (c <= 5 * n + 3), 1'b1);
  endtask
  initial
  begin
    int khz [5];
    logic [3:0] f, g;
    {resetn, enable_pin, ext_on, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, tc, ref_tick, st_cnt} = '0;
    wstrb = 4'hf;
    fls = 4'h0;
    gcs = 4'h0;
    void'($urandom(850));
    for (int i = 0; i < 6; i++)
    begin
      f = (i == 0) ? OPEN_CODE_FAULT : (i == 1) ? 4'h0 : (i == 2) ? 4'hf : $urandom;
      g = (i == 0) ? OPEN_CODE_GAIN : (i == 1) ? 4'hf : (i == 2) ? 4'h0 : $urandom;
      fls <= f;
      gcs <= g;
      do_reset();
      chk_straps(f, g);
      fls <= ~f;
      gcs <= ~g;
      repeat (30) @(posedge clk);
      chk_straps(f, g);
    end
    $display("strap decode test done");
    gcs <= 4'h2;
    do_reset();
    rdr(8'h40, rd, r);
    chk("unmapped_read", r, AXI_SLVERR);
    wr(OFS_LIMITS, 32'h0, r);
    chk("limits_write", r, AXI_SLVERR);
    wr(OFS_FAULT_LIMIT, 32'h232, r);
    chk("fault_write", fault_cfg, 10'h232);
    rdr(OFS_FAULT_LIMIT, rd, r);
    chk("fault_read", rd[9:0], 10'h232);
    wr(OFS_STORE, 32'h1, r);
    repeat (3) @(posedge clk);
    chk("store_pulse", st_cnt, 1);
    $display("register test done");
    enable_pin <= 1'b1;
    khz = '{595, 200, 1000, 200 + $urandom % 801, 200 + $urandom % 801};
    foreach (khz[i])
    begin
      wr(OFS_FREQ, khz[i], r);
      rdr(OFS_FREQ, rd, r);
      chk("freq_read", rd[23:0], {8'(ndiv(khz[i])), 16'(30000 / ndiv(khz[i]))});
      repeat (20) @(posedge clk);
      chk("sync_drive", sync_oe, 1'b1);
      chk("sync_out", sync_out, sw_clk);
      chk_period(ndiv(khz[i]));
    end
    $display("frequency test done");
    wr(OFS_FREQ, 555, r);
    ext_on <= 1'b1;
    wr(OFS_OPTIONS, 32'h1, r);
    repeat (300) @(posedge clk);
    chk("sync_input", sync_oe, 1'b0);
    // Three 1.8 us source periods span 270 cycles
    chk_period(54);
    ext_on <= 1'b0;
    repeat (700) @(posedge clk);
    chk("loss_run", run, 1'b0);
    rdr(OFS_MFR_STATUS, rd, r);
    chk("loss_flag", rd[0], 1'b1);
    enable_pin <= 1'b0;
    repeat (5) @(posedge clk);
    enable_pin <= 1'b1;
    repeat (40) @(posedge clk);
    rdr(OFS_MFR_STATUS, rd, r);
    chk("internal_again", {rd[2:1], sync_oe}, 3'b011);
    chk_period(ndiv(555));
    ext_on <= 1'b1;
    wr(OFS_OPTIONS, 32'h1, r);
    repeat (300) @(posedge clk);
    rdr(OFS_MFR_STATUS, rd, r);
    chk("resync", {rd[2], sync_oe}, 2'b10);
    $display("external clock test done");
    final_report();
  end
  initial
  begin
    #1ms;
    error_cnt++;
    final_report();
  end
endmodule
